// *** core/adcrb_device.sv ***
// Notes on behaviour
// R1: download bit with nonzero length code makes next writes coefficients
// R2: host sends length with download request
// R3: threshold select redirects next read
// R4: gain select redirects next read
// R5: offset select redirects next read
// R6: status select redirects next read
// R7: host writes zero to bit 10
// R8: sync bit starts synchronization pulse
// R9: bit 4 low bypasses FIR stage
// R10: bit 3 low bypasses first stage
// R11: decimation code: 0 bypass, 2^n
// R12: bits 15..9 clear themselves
// R13: host sets one read selector at most
// R14: control word 2 resets to 0x009b
// R15: clock select: 0 divides by two
// R16: bit 3 powers down converter
// R17: bit 2 selects low power mode
// R18: host writes one to bit 1
// R19: bit 0 powers down input amplifier
// R20: host recommends 0x0002 for control 2
// R21: address word then data word latched
// R22: coefficients upper half first, then checksum
// R23: control word 1 resets to 0x001a
// R24: read selection serves exactly one read
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module adcrb_device
	import adcrb_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	adcrb_link_if.device link,
	input wire logic [15:0] conv_result_i,
	input wire logic [15:0] status_word_i,
	output logic [15:0] ctrl1_o,
	output logic sync_pulse_o,
	output logic fir_stage_enable_o,
	output logic first_stage_enable_o,
	output logic [2:0] stage2_decimation_code_o,
	output logic [3:0] coeff_length_code_o,
	output logic clock_divide_select_o,
	output logic internal_clock_o,
	output logic full_power_down_o,
	output logic low_power_select_o,
	output logic input_amp_power_down_o,
	output logic download_active_o,
	output logic coeff_wr_o,
	output logic [31:0] coeff_word_o,
	output logic checksum_wr_o,
	output logic [15:0] checksum_o,
	output logic download_ok_flag_o
);
	typedef enum logic [1:0] {ADCRB_SRC_CONV, ADCRB_SRC_THR, ADCRB_SRC_GAIN, ADCRB_SRC_OFF} adcrb_src_type;
	typedef enum {ADCRB_ST_ADDR, ADCRB_ST_DATA, ADCRB_ST_COEF_HI, ADCRB_ST_COEF_LO, ADCRB_ST_CSUM} adcrb_state_type;

	adcrb_state_type state_q;
	logic [15:0] addr_q;
	logic [15:0] ctrl1_q, ctrl2_q, offset_q, gain_q, thresh_q;
	logic [1:0] src_q;
	logic src_stat_q;
	logic [15:0] hi_q;
	logic [6:0] coef_left_q;
	logic [15:0] sum_q;
	logic ok_q;
	logic div_q;
	logic [15:0] rd_data_q;
	logic rd_valid_q;
	logic ctrl1_wr;
	logic [15:0] d;

	function automatic logic [15:0] byte_sum(input logic [15:0] w);
		byte_sum = {8'h00, w[15:8]} + {8'h00, w[7:0]};
	endfunction

	assign d = link.wr_data;
	assign ctrl1_wr = link.wr_stb && state_q == ADCRB_ST_DATA && addr_q == ADCRB_ADDR_CTRL1;

	// link word sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ADCRB_ST_ADDR;
			addr_q <= 16'h0000;
		end else if (link.wr_stb) begin
			unique case (state_q)
				ADCRB_ST_ADDR: begin
					addr_q <= d; // R21
					state_q <= ADCRB_ST_DATA;
				end
				ADCRB_ST_DATA: begin
					if (ctrl1_wr && d[ADCRB_C1_DL] && d[ADCRB_C1_LEN_HI:ADCRB_C1_LEN_LO] != 4'h0)
						state_q <= ADCRB_ST_COEF_HI; // R1
					else if (ctrl1_wr && d[ADCRB_C1_DL])
						state_q <= ADCRB_ST_CSUM;
					else
						state_q <= ADCRB_ST_ADDR;
				end
				ADCRB_ST_COEF_HI: state_q <= ADCRB_ST_COEF_LO; // R22
				ADCRB_ST_COEF_LO: state_q <= (coef_left_q == 7'd1) ? ADCRB_ST_CSUM : ADCRB_ST_COEF_HI;
				ADCRB_ST_CSUM: state_q <= ADCRB_ST_ADDR;
			endcase
		end
	end

	// coefficient assembly and checksum
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hi_q <= 16'h0000;
			coef_left_q <= 7'd0;
			sum_q <= 16'h0000;
			ok_q <= 1'b0;
			coeff_wr_o <= 1'b0;
			coeff_word_o <= 32'h0;
			checksum_wr_o <= 1'b0;
			checksum_o <= 16'h0000;
		end else begin
			coeff_wr_o <= 1'b0;
			checksum_wr_o <= 1'b0;
			if (ctrl1_wr && d[ADCRB_C1_DL]) begin
				// length code counts coefficients in steps of six, odd codes only
				coef_left_q <= 7'((({3'b000, d[ADCRB_C1_LEN_HI:ADCRB_C1_LEN_LO]} + 7'd1) >> 1) * ADCRB_COEF_PER_STEP); // R2
				sum_q <= 16'h0000;
				ok_q <= 1'b0;
			end else if (link.wr_stb && state_q == ADCRB_ST_COEF_HI) begin
				hi_q <= d;
				sum_q <= sum_q + byte_sum(d);
			end else if (link.wr_stb && state_q == ADCRB_ST_COEF_LO) begin
				coeff_word_o <= {hi_q, d};
				coeff_wr_o <= 1'b1;
				coef_left_q <= coef_left_q - 7'd1;
				sum_q <= sum_q + byte_sum(d);
			end else if (link.wr_stb && state_q == ADCRB_ST_CSUM) begin
				checksum_o <= d;
				checksum_wr_o <= 1'b1;
				ok_q <= (d == sum_q);
			end
		end
	end

	// control word 1
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl1_q <= ADCRB_CTRL1_RST; // R23
			sync_pulse_o <= 1'b0;
		end else begin
			sync_pulse_o <= ctrl1_wr && d[ADCRB_C1_SYNC]; // R8
			if (ctrl1_wr)
				ctrl1_q <= d & ~ADCRB_C1_SELFCLR_MASK; // R12
		end
	end

	// control word 2 and other data registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl2_q <= ADCRB_CTRL2_RST; // R14
			offset_q <= ADCRB_OFFSET_RST;
			gain_q <= ADCRB_GAIN_RST;
			thresh_q <= ADCRB_THRESH_RST;
		end else if (link.wr_stb && state_q == ADCRB_ST_DATA) begin
			unique case (addr_q)
				ADCRB_ADDR_CTRL2: ctrl2_q <= d & ADCRB_C2_MASK;
				ADCRB_ADDR_OFFSET: offset_q <= d;
				ADCRB_ADDR_GAIN: gain_q <= d;
				ADCRB_ADDR_THRESH: thresh_q <= d;
				default: ;
			endcase
		end
	end

	// one-shot read source
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_q <= ADCRB_SRC_CONV;
			src_stat_q <= 1'b0;
		end else if (ctrl1_wr && d[ADCRB_C1_RD_THR:ADCRB_C1_RD_STAT] != 4'h0) begin
			// priority only matters if the host breaks the one-selector limit
			src_stat_q <= d[ADCRB_C1_RD_STAT]; // R6 R13
			if (d[ADCRB_C1_RD_THR])
				src_q <= ADCRB_SRC_THR; // R3
			else if (d[ADCRB_C1_RD_GAIN])
				src_q <= ADCRB_SRC_GAIN; // R4
			else if (d[ADCRB_C1_RD_OFF])
				src_q <= ADCRB_SRC_OFF; // R5
			else
				src_q <= ADCRB_SRC_CONV;
		end else if (link.rd_stb) begin
			src_q <= ADCRB_SRC_CONV; // R24
			src_stat_q <= 1'b0;
		end
	end

	// read data path
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= link.rd_stb;
			if (link.rd_stb) begin
				if (src_stat_q)
					rd_data_q <= status_word_i;
				else
					unique case (adcrb_src_type'(src_q))
						ADCRB_SRC_THR: rd_data_q <= thresh_q;
						ADCRB_SRC_GAIN: rd_data_q <= gain_q;
						ADCRB_SRC_OFF: rd_data_q <= offset_q;
						ADCRB_SRC_CONV: rd_data_q <= conv_result_i;
					endcase
			end
		end
	end

	// internal clock enable derived from master clock
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			div_q <= 1'b0;
		else
			div_q <= ~div_q;
	end

	assign internal_clock_o = ctrl2_q[ADCRB_C2_CLKSEL] ? 1'b1 : div_q; // R15
	assign link.rd_data = rd_data_q;
	assign link.rd_valid = rd_valid_q;
	assign ctrl1_o = ctrl1_q;
	assign fir_stage_enable_o = ctrl1_q[ADCRB_C1_FIR_EN]; // R9
	assign first_stage_enable_o = ctrl1_q[ADCRB_C1_F1_EN]; // R10
	assign stage2_decimation_code_o = (ctrl1_q[ADCRB_C1_DECIM_HI:ADCRB_C1_DECIM_LO] > ADCRB_DECIM_MAX) ?
		ADCRB_DECIM_MAX : ctrl1_q[ADCRB_C1_DECIM_HI:ADCRB_C1_DECIM_LO]; // R11
	assign coeff_length_code_o = ctrl1_q[ADCRB_C1_LEN_HI:ADCRB_C1_LEN_LO];
	assign clock_divide_select_o = ctrl2_q[ADCRB_C2_CLKSEL];
	assign full_power_down_o = ctrl2_q[ADCRB_C2_PWRDN]; // R16
	assign low_power_select_o = ctrl2_q[ADCRB_C2_LOWPOW]; // R17
	assign input_amp_power_down_o = ctrl2_q[ADCRB_C2_AMPPD]; // R19
	assign download_active_o = state_q inside {ADCRB_ST_COEF_HI, ADCRB_ST_COEF_LO, ADCRB_ST_CSUM};
	assign download_ok_flag_o = ok_q;
endmodule
`default_nettype wire

// *** core/adcrb_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcrb_host
	import adcrb_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	adcrb_link_if.host link
);
	typedef enum {ADCRB_H_IDLE, ADCRB_H_SEND_ADDR, ADCRB_H_SEND_DATA, ADCRB_H_WAIT_RD} adcrb_hstate_type;

	adcrb_hstate_type st_q;
	logic [15:0] addr_q, data_q, rdata_q;
	logic done_q, ack_q;
	logic wr_stb_q, rd_stb_q;
	logic [15:0] wr_data_q;
	logic busy;
	logic [31:0] rd_mux;

	assign busy = st_q != ADCRB_H_IDLE;

	// single-cycle wait state so reads answer from a flop
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_i || avs_write_i) && !ack_q;
	end
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

	always_comb begin
		rd_mux = 32'h0;
		unique case (avs_address_i)
			ADCRB_H_ADDR: rd_mux = {16'h0000, addr_q};
			ADCRB_H_DATA: rd_mux = {16'h0000, rdata_q};
			ADCRB_H_STAT: rd_mux = {30'h0, done_q, busy};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			avs_readdata_o <= 32'h0;
		else if (avs_read_i && !ack_q)
			avs_readdata_o <= rd_mux;
	end

	// order sequencer: go sends address then data word, rd strobes one read
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ADCRB_H_IDLE;
			addr_q <= 16'h0000;
			data_q <= 16'h0000;
			rdata_q <= 16'h0000;
			done_q <= 1'b0;
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
			wr_data_q <= 16'h0000;
		end else begin
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
			if (avs_write_i && ack_q && avs_address_i == ADCRB_H_ADDR)
				addr_q <= avs_writedata_i[15:0];
			if (avs_write_i && ack_q && avs_address_i == ADCRB_H_DATA)
				data_q <= avs_writedata_i[15:0];
			unique case (st_q)
				ADCRB_H_IDLE: begin
					if (avs_write_i && ack_q && avs_address_i == ADCRB_H_CTRL) begin
						done_q <= 1'b0;
						if (avs_writedata_i[ADCRB_H_CTRL_RD]) begin
							rd_stb_q <= 1'b1;
							st_q <= ADCRB_H_WAIT_RD;
						end else if (avs_writedata_i[ADCRB_H_CTRL_GO])
							st_q <= ADCRB_H_SEND_ADDR;
					end
				end
				ADCRB_H_SEND_ADDR: begin
					wr_stb_q <= 1'b1;
					wr_data_q <= addr_q; // R21
					// device counts words, so during a download both slots carry coefficients
					st_q <= ADCRB_H_SEND_DATA;
				end
				ADCRB_H_SEND_DATA: begin
					wr_stb_q <= 1'b1;
					if (addr_q == ADCRB_ADDR_CTRL1)
						wr_data_q <= data_q & ~(16'h0001 << ADCRB_C1_ZERO); // R7
					else if (addr_q == ADCRB_ADDR_CTRL2)
						wr_data_q <= data_q | (16'h0001 << ADCRB_C2_ONE); // R18
					else
						wr_data_q <= data_q;
					done_q <= 1'b1;
					st_q <= ADCRB_H_IDLE;
				end
				ADCRB_H_WAIT_RD: begin
					if (link.rd_valid) begin
						rdata_q <= link.rd_data;
						done_q <= 1'b1;
						st_q <= ADCRB_H_IDLE;
					end
				end
			endcase
		end
	end

	assign link.wr_stb = wr_stb_q;
	assign link.wr_data = wr_data_q;
	assign link.rd_stb = rd_stb_q;
endmodule
`default_nettype wire

// *** core/adcrb_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface adcrb_link_if;
	logic wr_stb;
	logic [15:0] wr_data;
	logic rd_stb;
	logic [15:0] rd_data;
	logic rd_valid;
	modport device (input wr_stb, input wr_data, input rd_stb, output rd_data, output rd_valid);
	modport host (output wr_stb, output wr_data, output rd_stb, input rd_data, input rd_valid);
endinterface
`default_nettype wire

// *** core/adcrb_pkg.sv ***
package adcrb_pkg;
	localparam int ADCRB_DW = 16;
	localparam int ADCRB_AW = 16;
	// register addresses on the link
	localparam logic [15:0] ADCRB_ADDR_CTRL1 = 16'h0001;
	localparam logic [15:0] ADCRB_ADDR_CTRL2 = 16'h0002;
	localparam logic [15:0] ADCRB_ADDR_OFFSET = 16'h0003;
	localparam logic [15:0] ADCRB_ADDR_GAIN = 16'h0004;
	localparam logic [15:0] ADCRB_ADDR_THRESH = 16'h0005;
	// reset values and the recommended control 2 value
	localparam logic [15:0] ADCRB_CTRL1_RST = 16'h001a;
	localparam logic [15:0] ADCRB_CTRL2_RST = 16'h009b;
	localparam logic [15:0] ADCRB_CTRL2_RECOMMENDED = 16'h0002;
	localparam logic [15:0] ADCRB_OFFSET_RST = 16'h0000;
	localparam logic [15:0] ADCRB_GAIN_RST = 16'ha000;
	localparam logic [15:0] ADCRB_THRESH_RST = 16'hcccc;
	// control word 1 fields
	localparam int ADCRB_C1_DL = 15;
	localparam int ADCRB_C1_RD_THR = 14;
	localparam int ADCRB_C1_RD_GAIN = 13;
	localparam int ADCRB_C1_RD_OFF = 12;
	localparam int ADCRB_C1_RD_STAT = 11;
	localparam int ADCRB_C1_ZERO = 10;
	localparam int ADCRB_C1_SYNC = 9;
	localparam int ADCRB_C1_LEN_HI = 8;
	localparam int ADCRB_C1_LEN_LO = 5;
	localparam int ADCRB_C1_FIR_EN = 4;
	localparam int ADCRB_C1_F1_EN = 3;
	localparam int ADCRB_C1_DECIM_HI = 2;
	localparam int ADCRB_C1_DECIM_LO = 0;
	localparam logic [2:0] ADCRB_DECIM_MAX = 3'h5;
	localparam logic [15:0] ADCRB_C1_SELFCLR_MASK = 16'hfe00;
	// control word 2 fields
	localparam int ADCRB_C2_CLKSEL = 5;
	localparam int ADCRB_C2_PWRDN = 3;
	localparam int ADCRB_C2_LOWPOW = 2;
	localparam int ADCRB_C2_ONE = 1;
	localparam int ADCRB_C2_AMPPD = 0;
	localparam logic [15:0] ADCRB_C2_MASK = 16'h002f;
	// coefficient words: 6 per length step, two words each
	localparam int ADCRB_COEF_PER_STEP = 6;
	// host register offsets (avalon byte addresses)
	localparam logic [3:0] ADCRB_H_ADDR = 4'h0;
	localparam logic [3:0] ADCRB_H_DATA = 4'h4;
	localparam logic [3:0] ADCRB_H_CTRL = 4'h8;
	localparam logic [3:0] ADCRB_H_STAT = 4'hc;
	localparam int ADCRB_H_CTRL_GO = 0;
	localparam int ADCRB_H_CTRL_RD = 1;
	localparam int ADCRB_H_STAT_BUSY = 0;
	localparam int ADCRB_H_STAT_DONE = 1;
endpackage

// *** verif/adcrb_link_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcrb_link_checker
	import adcrb_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic wr_stb,
	input wire logic [15:0] wr_data,
	input wire logic rd_stb,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_read_answer_next: assert property (rd_stb |=> rd_valid)
		else $error("read request got no answer");
	a_valid_has_cause: assert property (rd_valid |-> $past(rd_stb))
		else $error("read answer without request");
	a_readback_holds: assert property (!rd_valid |-> $stable(rd_data))
		else $error("read data moved outside an answer");
	a_read_single: assert property (rd_stb |=> !rd_stb)
		else $error("read request longer than one cycle");
	a_word_pair: assert property ($rose(wr_stb) |=> wr_stb ##1 !wr_stb)
		else $error("link words not sent as a pair");
	a_link_exclusive: assert property (!(wr_stb && rd_stb))
		else $error("write and read strobes together");
	a_ctrl1_zero_bit: assert property ($rose(wr_stb) && wr_data == ADCRB_ADDR_CTRL1 |=> !wr_data[ADCRB_C1_ZERO])
		else $error("control word 1 bit 10 sent as one");
	a_ctrl2_one_bit: assert property ($rose(wr_stb) && wr_data == ADCRB_ADDR_CTRL2 |=> wr_data[ADCRB_C2_ONE])
		else $error("control word 2 bit 1 sent as zero");
endmodule
`default_nettype wire

// *** verif/test_adc_control_register_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_adc_control_register_bank
	import adcrb_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, coeff_word, first_coeff, q;
	logic [15:0] ctrl1, sum, csum;
	logic [3:0] len_code;
	logic [2:0] decim;
	logic avs_waitrequest, sync_pulse, fir_en, f1_en, clk_sel, ico, pwr_down, lp, amp, dl_active, coeff_wr, ok_flag, t;
	logic csum_wr;
	int errors = 0, checks_done = 0, cycles = 0, sync_cnt = 0, coeff_cnt = 0, csum_cnt = 0, s0;
	// address, data, expected {length, fir, first, decimation, clock select, power down, low power, amp}
	logic [47:0] rows [13] = '{48'h0002_0002_01a0, 48'h0002_0020_01a8, 48'h0002_0008_01a4, 48'h0002_0004_01a2,
		48'h0002_0001_01a1, 48'h0002_0000_01a0, 48'h0001_0000_0000, 48'h0001_0400_0000, 48'h0001_001d_01d0,
		48'h0001_000c_00c0, 48'h0001_0013_0130, 48'h0001_01e1_1e10, 48'h0001_0007_0050};
	logic [15:0] cw [12] = '{16'h032b, 16'h9688, 16'h01bf, 16'h183c, 16'h0015, 16'h6626, 16'h04a8, 16'h1e6a,
		16'h045f, 16'h2a96, 16'h002c, 16'h49c2};
	logic [15:0] sel_exp [4] = '{16'h5a5a, 16'h0777, 16'ha000, 16'hcccc};
	adcrb_link_if lnk();
	adcrb_host i_adcrb_host(.sys_clk_i(sys_clk), .rst_n_i(rst_n), .avs_address_i(avs_address), .avs_read_i(avs_read),
		.avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest), .link(lnk));
	adcrb_device i_adcrb_device(.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(lnk), .conv_result_i(16'h1234),
		.status_word_i(16'h5a5a), .ctrl1_o(ctrl1), .sync_pulse_o(sync_pulse), .fir_stage_enable_o(fir_en),
		.first_stage_enable_o(f1_en), .stage2_decimation_code_o(decim), .coeff_length_code_o(len_code),
		.clock_divide_select_o(clk_sel), .internal_clock_o(ico), .full_power_down_o(pwr_down),
		.low_power_select_o(lp), .input_amp_power_down_o(amp), .download_active_o(dl_active), .coeff_wr_o(coeff_wr),
		.coeff_word_o(coeff_word), .checksum_wr_o(csum_wr), .checksum_o(csum), .download_ok_flag_o(ok_flag));
	adcrb_link_checker i_adcrb_link_checker(.sys_clk_i(sys_clk), .rst_n_i(rst_n), .wr_stb(lnk.wr_stb),
		.wr_data(lnk.wr_data), .rd_stb(lnk.rd_stb), .rd_data(lnk.rd_data), .rd_valid(lnk.rd_valid));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] obs();
		return {3'h0, len_code, fir_en, f1_en, decim, clk_sel, pwr_down, lp, amp};
	endfunction
	task summarize();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// entered right after a rising edge; returns one edge after release
	task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		chk(avs_waitrequest, 0, "bus answer");
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task cmd(input logic [31:0] c);
		int n;
		n = 0;
		bus(ADCRB_H_CTRL, 1'b1, c);
		repeat (2) @(posedge sys_clk);
		do begin
			bus(ADCRB_H_STAT, 1'b0, 32'h0);
			n++;
		end while (q[1:0] !== 2'b10 && n < 50);
		chk(q[1:0], 2'b10, "command done");
	endtask
	task go(input logic [15:0] a, input logic [15:0] d);
		bus(ADCRB_H_ADDR, 1'b1, {16'h0, a});
		bus(ADCRB_H_DATA, 1'b1, {16'h0, d});
		cmd(32'h1);
	endtask
	task rd();
		cmd(32'h2);
		bus(ADCRB_H_DATA, 1'b0, 32'h0);
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (sync_pulse === 1'b1) sync_cnt <= sync_cnt + 1;
		if (coeff_wr === 1'b1) begin
			if (coeff_cnt == 0) first_coeff <= coeff_word;
			coeff_cnt <= coeff_cnt + 1;
		end
		if (csum_wr === 1'b1) csum_cnt <= csum_cnt + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk(obs(), 16'h01a5, "reset fields");
		chk(ctrl1, ADCRB_CTRL1_RST, "control 1 reset");
		for (int i = 0; i < 13; i++) begin
			go(rows[i][47:32], rows[i][31:16]);
			chk(obs(), rows[i][15:0], "fields");
			if (rows[i][3]) chk(ico, 1, "undivided clock");
		end
		@(negedge sys_clk) t = ico;
		@(negedge sys_clk) chk(ico ^ t, 1, "clock divided by two");
		@(posedge sys_clk);
		s0 = sync_cnt;
		go(ADCRB_ADDR_CTRL1, 16'h021a);
		chk(sync_cnt - s0, 1, "sync pulse");
		chk(ctrl1, ADCRB_CTRL1_RST, "sync bit cleared");
		go(ADCRB_ADDR_OFFSET, 16'h0777);
		for (int b = 0; b < 4; b++) begin
			go(ADCRB_ADDR_CTRL1, 16'h001a | (16'h0800 << b));
			chk(ctrl1, ADCRB_CTRL1_RST, "selector cleared");
			rd();
			chk(q[15:0], sel_exp[b], "selected read");
			rd();
			chk(q[15:0], 16'h1234, "result again");
		end
		sum = 16'h0;
		for (int i = 0; i < 12; i++) sum += cw[i][15:8] + cw[i][7:0];
		go(ADCRB_ADDR_CTRL1, 16'h803a);
		chk(dl_active, 1, "download entered");
		for (int i = 0; i < 6; i++) go(cw[2*i], cw[2*i+1]);
		chk(coeff_cnt, 6, "coefficient count");
		chk(first_coeff, {cw[0], cw[1]}, "upper half first");
		go(sum, ADCRB_ADDR_CTRL1);
		chk(ok_flag, 1, "checksum accepted");
		chk(csum, sum, "checksum word");
		chk(csum_cnt, 1, "one checksum strobe");
		chk(dl_active, 0, "download left");
		go(16'h081a, ADCRB_ADDR_CTRL2);
		rd();
		chk(q[15:0], 16'h5a5a, "status after download");
		// reset with an address word still pending
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(obs(), 16'h01a5, "second reset");
		rst_n <= 1'b1;
		go(ADCRB_ADDR_CTRL2, ADCRB_CTRL2_RECOMMENDED);
		chk(obs(), 16'h01a0, "pairing after reset");
		summarize();
	end
endmodule
`default_nettype wire
